// ==== inc/msr_defs.svh ====
// Constants for the mirror control and source security status register block.
// Assumes an APB slave with 32-bit data; registers hold 16 bits in the low half.
// Contract
// - Unmonitored forwarding bit lets the monitor port also get its ordinary traffic.
// - Bits 7:6 hold the port 5 transmit mirror option.
// - Bits 5:4 hold the port 5 receive mirror option.
// - Bits 3:2 hold the port 4 transmit mirror option.
// - Bits 1:0 hold the port 4 receive mirror option.
// - Per-port intrusion flags in bits 11:6, cleared by a read.
// - Bits 11:6 of first status register show per-port first lock.
// - Bits 5:0 of first status register show ports closed by violation.
// - Bits 5:0 of second status register show per-port link lock events.
// - Transmit option: 00 off, 01 all, 10 destination match, 11 source match.
// - Receive option: 00 off, 01 all, 10 destination match, 11 source match.
// - Mirrored traffic goes to the port named by the assigned-port field.
`ifndef MSR_DEFS_SVH
`define MSR_DEFS_SVH
// Register indices as printed; byte address is four times the index
`define MSR_IDX_MIRR_CTRL 12'h137
`define MSR_IDX_SEC_STAT0 12'h139
`define MSR_IDX_SEC_VIOL 12'h138
`define MSR_IDX_SEC_STAT1 12'h13A
`define MSR_IDX_IRQ_STAT 12'h140
`define MSR_IDX_IRQ_MASK 12'h141
`define MSR_MIRR_CTRL_RST 16'h0000
`define MSR_BIT_ME 15
`define MSR_BIT_MCA 14
`define MSR_BIT_MRA 13
`define MSR_BIT_MPA 12
`define MSR_BIT_MLA 11
`define MSR_BIT_MSA 10
`define MSR_BIT_FORWARD_UNMONITORED_TO_MONITOR 8
`define MSR_LSB_PORT5_TX_MIRROR_OPTION 6
`define MSR_LSB_PORT5_RX_MIRROR_OPTION 4
`define MSR_LSB_PORT4_TX_MIRROR_OPTION 2
`define MSR_LSB_PORT4_RX_MIRROR_OPTION 0
`define MSR_LSB_PSI 6
`define MSR_LSB_FL 6
`define MSR_LSB_PL 0
`define MSR_LSB_LL 0
`define MSR_NPORT 6
`endif

// ==== inc/msr_pkg.sv ====
// Types for the mirror control and source security status register block.
// Assumes the constants header is compiled alongside.
package msr_pkg;
    // Mirror option encoding, shared by receive and transmit fields
    typedef enum logic [1:0] {
        MSR_MIRR_OFF = 2'h0,
        MSR_MIRR_ALL = 2'h1,
        MSR_MIRR_DA = 2'h2,
        MSR_MIRR_SA = 2'h3
    } msr_mirr_opt_t;
    typedef logic [5:0] msr_port_vec_t;
endpackage : msr_pkg

// ==== core/msr_regs.sv ====
// Mirror control and source security status registers with mirror decision logic.
// Assumes an APB master on clk_i and switch-core event pulses synchronous to clk_i.
`timescale 1ns/1ns
`include "msr_defs.svh"
module msr_regs (
    input wire logic clk_i, // System clock, 50 MHz
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB enable
    input wire logic pwrite_i, // APB direction
    input wire logic [31:0] paddr_i, // APB byte address
    input wire logic [31:0] pwdata_i, // APB write data
    output logic [31:0] prdata_o, // APB read data
    output logic pready_o, // APB ready
    output logic pslverr_o, // APB error on unmapped address
    input wire msr_pkg::msr_port_vec_t intrusion_i, // Source intrusion pulses
    input wire msr_pkg::msr_port_vec_t first_lock_i, // Port locked an address
    input wire msr_pkg::msr_port_vec_t port_closed_i, // Port closed by violation
    input wire msr_pkg::msr_port_vec_t link_lock_i, // Link lock event pulses
    input wire logic [2:0] assigned_monitor_port_i, // Monitor port number
    input wire logic frm_valid_i, // Frame descriptor valid
    input wire logic [2:0] frm_src_port_i, // Receiving port
    input wire msr_pkg::msr_port_vec_t frm_dest_ports_i, // Ordinary destination ports
    input wire logic frm_da_match_i, // Destination equals assigned address
    input wire logic frm_sa_match_i, // Source equals assigned address
    input wire logic frm_crc_err_i, // Frame has CRC error
    input wire logic frm_rx_err_i, // Frame has receive error
    input wire logic frm_pause_i, // Frame is PAUSE
    input wire logic frm_long_i, // Frame is over-long
    input wire logic frm_short_i, // Frame is short
    output msr_pkg::msr_port_vec_t fwd_ports_o, // Final destination port set
    output logic fwd_valid_o, // Final port set valid
    output logic mirror_global_enable_o, // Mirror enable bit
    output logic irq_o // Level interrupt
);
    import msr_pkg::*;

    // ******************************
    // Register storage
    // ******************************
    logic [15:0] mirror_control_high_ports_q;
    msr_port_vec_t source_intrusion_flags_q;
    msr_port_vec_t link_lock_flags_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    msr_port_vec_t fwd_ports_q;
    logic fwd_valid_q;
    logic [31:0] prdata_q;

    // Access decode: printed offsets are indices, byte address is four times
    function automatic logic hit(input logic [31:0] a, input logic [11:0] idx);
        hit = (a[31:14] == 18'h00000) && (a[13:2] == idx) && (a[1:0] == 2'h0);
    endfunction : hit

    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    logic rd_setup;
    assign acc = psel_i && penable_i;
    // Read data is loaded in the setup cycle so it stands at the access edge
    assign rd_setup = psel_i && !penable_i && !pwrite_i;
    assign wr = acc && pwrite_i;
    assign rd = acc && !pwrite_i;
    assign mapped = hit(paddr_i, `MSR_IDX_MIRR_CTRL) || hit(paddr_i, `MSR_IDX_SEC_STAT0)
        || hit(paddr_i, `MSR_IDX_SEC_VIOL) || hit(paddr_i, `MSR_IDX_SEC_STAT1)
        || hit(paddr_i, `MSR_IDX_IRQ_STAT) || hit(paddr_i, `MSR_IDX_IRQ_MASK);
    // Zero wait states keep the bus simple
    assign pready_o = 1'b1;
    assign pslverr_o = acc && !mapped;
    assign prdata_o = prdata_q;

    // Mirror control register, all sixteen bits writable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mirror_control_high_ports_q <= `MSR_MIRR_CTRL_RST;
        end else if (wr && hit(paddr_i, `MSR_IDX_MIRR_CTRL)) begin
            mirror_control_high_ports_q <= pwdata_i[15:0];
        end
    end

    // Intrusion flags: only reported bits clear, so events after the setup edge survive
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            source_intrusion_flags_q <= 6'h00;
        end else if (rd && hit(paddr_i, `MSR_IDX_SEC_VIOL)) begin
            source_intrusion_flags_q <= (source_intrusion_flags_q
                & ~prdata_q[`MSR_LSB_PSI +: 6]) | intrusion_i;
        end else begin
            source_intrusion_flags_q <= source_intrusion_flags_q | intrusion_i;
        end
    end

    // Link lock events are sticky until reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_lock_flags_q <= 6'h00;
        end else begin
            link_lock_flags_q <= link_lock_flags_q | link_lock_i;
        end
    end

    // Interrupt status: bit0 intrusion, bit1 link lock; write one to clear, set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= 2'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((wr && hit(paddr_i, `MSR_IDX_IRQ_STAT))
                ? pwdata_i[1:0] : 2'h0)) | {(|link_lock_i), (|intrusion_i)};
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_q <= 2'h0;
        end else if (wr && hit(paddr_i, `MSR_IDX_IRQ_MASK)) begin
            irq_mask_q <= pwdata_i[1:0];
        end
    end
    // A set mask bit blocks its status bit from the interrupt
    assign irq_o = |(irq_stat_q & ~irq_mask_q);

    // Read data mux, registered on the setup cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prdata_q <= 32'h00000000;
        end else if (rd_setup) begin
            prdata_q <= 32'h00000000;
            if (hit(paddr_i, `MSR_IDX_MIRR_CTRL)) begin
                prdata_q[15:0] <= mirror_control_high_ports_q;
            end
            if (hit(paddr_i, `MSR_IDX_SEC_STAT0)) begin
                prdata_q[`MSR_LSB_FL +: 6] <= first_lock_i;
                prdata_q[`MSR_LSB_PL +: 6] <= port_closed_i;
            end
            if (hit(paddr_i, `MSR_IDX_SEC_VIOL)) begin
                prdata_q[`MSR_LSB_PSI +: 6] <= source_intrusion_flags_q;
            end
            if (hit(paddr_i, `MSR_IDX_SEC_STAT1)) begin
                prdata_q[`MSR_LSB_LL +: 6] <= link_lock_flags_q;
            end
            if (hit(paddr_i, `MSR_IDX_IRQ_STAT)) begin
                prdata_q[1:0] <= irq_stat_q;
            end
            if (hit(paddr_i, `MSR_IDX_IRQ_MASK)) begin
                prdata_q[1:0] <= irq_mask_q;
            end
        end
    end

    // ******************************
    // Mirror decision
    // ******************************
    // Option match, shared by receive and transmit selections
    function automatic logic opt_hit(input logic [1:0] o, input logic da, input logic sa);
        unique case (msr_mirr_opt_t'(o))
            MSR_MIRR_OFF: opt_hit = 1'b0;
            MSR_MIRR_ALL: opt_hit = 1'b1;
            MSR_MIRR_DA: opt_hit = da;
            MSR_MIRR_SA: opt_hit = sa;
        endcase
    endfunction : opt_hit

    logic [1:0] p4_rx;
    logic [1:0] p4_tx;
    logic [1:0] p5_rx;
    logic [1:0] p5_tx;
    logic err_ok;
    logic sel;
    msr_port_vec_t mon_vec;
    assign p4_rx = mirror_control_high_ports_q[`MSR_LSB_PORT4_RX_MIRROR_OPTION +: 2];
    assign p4_tx = mirror_control_high_ports_q[`MSR_LSB_PORT4_TX_MIRROR_OPTION +: 2];
    assign p5_rx = mirror_control_high_ports_q[`MSR_LSB_PORT5_RX_MIRROR_OPTION +: 2];
    assign p5_tx = mirror_control_high_ports_q[`MSR_LSB_PORT5_TX_MIRROR_OPTION +: 2];
    assign mirror_global_enable_o = mirror_control_high_ports_q[`MSR_BIT_ME];
    // Faulty or special frames only mirror when their flag allows it
    assign err_ok = (!frm_crc_err_i || mirror_control_high_ports_q[`MSR_BIT_MCA])
        && (!frm_rx_err_i || mirror_control_high_ports_q[`MSR_BIT_MRA])
        && (!frm_pause_i || mirror_control_high_ports_q[`MSR_BIT_MPA])
        && (!frm_long_i || mirror_control_high_ports_q[`MSR_BIT_MLA])
        && (!frm_short_i || mirror_control_high_ports_q[`MSR_BIT_MSA]);
    // Ports 0-3 options live elsewhere; only ports 4 and 5 are selected here
    assign sel = mirror_global_enable_o && err_ok && (
        (frm_src_port_i == 3'h4 && opt_hit(p4_rx, frm_da_match_i, frm_sa_match_i))
        || (frm_src_port_i == 3'h5 && opt_hit(p5_rx, frm_da_match_i, frm_sa_match_i))
        || (frm_dest_ports_i[4] && opt_hit(p4_tx, frm_da_match_i, frm_sa_match_i))
        || (frm_dest_ports_i[5] && opt_hit(p5_tx, frm_da_match_i, frm_sa_match_i)));
    assign mon_vec = (assigned_monitor_port_i < 3'h6)
        ? msr_port_vec_t'(6'h01 << assigned_monitor_port_i) : 6'h00;

    // Forwarding result: monitor loses ordinary traffic only when ME is set and the forwarding bit is clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fwd_ports_q <= 6'h00;
            fwd_valid_q <= 1'b0;
        end else begin
            fwd_valid_q <= frm_valid_i;
            if (sel) begin
                fwd_ports_q <= frm_dest_ports_i | mon_vec;
            end else if (mirror_global_enable_o
                && !mirror_control_high_ports_q[`MSR_BIT_FORWARD_UNMONITORED_TO_MONITOR]) begin
                fwd_ports_q <= frm_dest_ports_i & ~mon_vec;
            end else begin
                fwd_ports_q <= frm_dest_ports_i;
            end
        end
    end
    assign fwd_ports_o = fwd_ports_q;
    assign fwd_valid_o = fwd_valid_q;
endmodule : msr_regs

// ==== dv/msr_regs_asserts.sv ====
// Concurrent checks on the ports of the mirror and security status block.
// Assumes binding to msr_regs; sees its ports only, one clock domain.
`timescale 1ns/1ns
module msr_regs_asserts (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB enable
    input wire logic pwrite_i, // APB direction
    input wire logic [31:0] paddr_i, // APB address
    input wire logic [31:0] pwdata_i, // APB write data
    input wire logic [31:0] prdata_o, // APB read data
    input wire logic pready_o, // APB ready
    input wire logic pslverr_o, // APB error
    input wire msr_pkg::msr_port_vec_t intrusion_i, // Intrusion pulses
    input wire msr_pkg::msr_port_vec_t first_lock_i, // First lock
    input wire msr_pkg::msr_port_vec_t port_closed_i, // Port closed
    input wire logic frm_valid_i, // Frame valid
    input wire msr_pkg::msr_port_vec_t frm_dest_ports_i, // Ordinary ports
    input wire msr_pkg::msr_port_vec_t fwd_ports_o, // Final ports
    input wire logic fwd_valid_o, // Final valid
    input wire logic mirror_global_enable_o, // Enable bit
    input wire logic irq_o // Interrupt
);
    import msr_pkg::*;
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    wire acc = psel_i && penable_i;
    // A read of the violation flags, used twice to see the clear
    sequence s_viol_rd;
        acc && !pwrite_i && paddr_i == 32'h4E0 && intrusion_i == 6'h00;
    endsequence
    a_reset_quiet: assert property (rst_i |=> !fwd_valid_o && !irq_o && prdata_o == 32'h0)
        else $error("outputs not cleared by reset");
    a_ready_always: assert property (disable iff (rst_i) pready_o)
        else $error("ready dropped");
    a_slverr_map: assert property (disable iff (rst_i) acc |-> pslverr_o ==
        !(paddr_i inside {32'h4DC, 32'h4E0, 32'h4E4, 32'h4E8, 32'h500, 32'h504}))
        else $error("error response wrong for address");
    a_enable_write: assert property (disable iff (rst_i) acc && pwrite_i && paddr_i == 32'h4DC
        |=> mirror_global_enable_o == $past(pwdata_i[15]))
        else $error("enable bit did not follow write");
    a_frame_timing: assert property (disable iff (rst_i) frm_valid_i |=> fwd_valid_o)
        else $error("no result one cycle after frame");
    a_mirror_off: assert property (disable iff (rst_i) frm_valid_i && !mirror_global_enable_o
        |=> fwd_ports_o == $past(frm_dest_ports_i))
        else $error("ports altered while mirroring off");
    a_status_live: assert property (disable iff (rst_i)
        acc && !pwrite_i && paddr_i == 32'h4E4
        |-> prdata_o == {20'h0, $past(first_lock_i), $past(port_closed_i)})
        else $error("lock status read wrong");
    a_viol_clear: assert property (disable iff (rst_i)
        s_viol_rd ##1 intrusion_i == 6'h00 ##1 (intrusion_i == 6'h00 && psel_i
        && !penable_i && paddr_i == 32'h4E0) ##1 s_viol_rd |-> prdata_o == 32'h0)
        else $error("intrusion flags not cleared by read");
endmodule : msr_regs_asserts

bind msr_regs msr_regs_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .intrusion_i(intrusion_i), .first_lock_i(first_lock_i), .port_closed_i(port_closed_i),
    .frm_valid_i(frm_valid_i), .frm_dest_ports_i(frm_dest_ports_i),
    .fwd_ports_o(fwd_ports_o), .fwd_valid_o(fwd_valid_o),
    .mirror_global_enable_o(mirror_global_enable_o), .irq_o(irq_o));

// ==== dv/test_mirror_and_security_status_regs.sv ====
// Self-checking bench for the mirror and security status register block.
// Assumes msr_regs and its package are compiled first; monitor port 0 unless set.
`timescale 1ns/1ns
module test_mirror_and_security_status_regs;
    import msr_pkg::*;
    logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, frm_valid_i = 0;
    logic [31:0] paddr_i = 0, pwdata_i = 0, prdata_o, rd;
    logic [2:0] mon = 0, src = 0;
    logic [4:0] flg = 0;
    logic da = 0, sa = 0, pready_o, pslverr_o, fwd_valid_o, me_o, irq_o, err;
    msr_port_vec_t intr = 0, fl = 0, pc = 0, ll = 0, dst = 0, fwd_ports_o;
    int mismatches = 0, cmp_count = 0;
    always #10 clk_i = ~clk_i;
    msr_regs dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .intrusion_i(intr), .first_lock_i(fl),
        .port_closed_i(pc), .link_lock_i(ll), .assigned_monitor_port_i(mon),
        .frm_valid_i(frm_valid_i), .frm_src_port_i(src), .frm_dest_ports_i(dst),
        .frm_da_match_i(da), .frm_sa_match_i(sa), .frm_crc_err_i(flg[4]),
        .frm_rx_err_i(flg[3]), .frm_pause_i(flg[2]), .frm_long_i(flg[1]),
        .frm_short_i(flg[0]), .fwd_ports_o(fwd_ports_o), .fwd_valid_o(fwd_valid_o),
        .mirror_global_enable_o(me_o), .irq_o(irq_o));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_of_test;
        if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Read data and error are taken at the edge where ready is seen high
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        err = pslverr_o;
        rd = prdata_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask : apb
    task automatic frame(input logic [2:0] s, input msr_port_vec_t d, input logic [1:0] m,
        input logic [4:0] f, input msr_port_vec_t exp);
        @(posedge clk_i);
        frm_valid_i <= 1;
        src <= s;
        dst <= d;
        {da, sa} <= m;
        flg <= f;
        @(posedge clk_i);
        frm_valid_i <= 0;
        #1 chk(fwd_valid_o, 1);
        chk(fwd_ports_o, exp);
    endtask : frame
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        apb(0, 32'h4DC, 0); chk(rd, 0);
        apb(1, 32'h4DC, 32'hFFFFFFFF);
        apb(0, 32'h4DC, 0); chk(rd, 32'hFFFF);
        apb(1, 32'h4EC, 1); chk(err, 1);
        apb(0, 32'h4EC, 0); chk(rd, 0);
        @(posedge clk_i) {fl, pc} <= 12'h56A;
        apb(0, 32'h4E4, 0); chk(rd, 32'h56A);
    endtask : t_regs
    // Intrusion and link lock pulses feed flags and the interrupt
    task automatic t_events;
        apb(1, 32'h504, 0);
        @(posedge clk_i) {intr, ll} <= {6'h21, 6'h09};
        @(posedge clk_i) {intr, ll} <= 12'h0;
        apb(0, 32'h4E0, 0); chk(rd, 32'h840);
        apb(0, 32'h4E0, 0); chk(rd, 0);
        apb(0, 32'h4E8, 0); chk(rd, 32'h9);
        @(negedge clk_i) chk(irq_o, 1);
        apb(1, 32'h500, 3);
        @(negedge clk_i) chk(irq_o, 0);
        apb(1, 32'h504, 1);
        @(posedge clk_i) intr <= 6'h04;
        @(posedge clk_i) intr <= 0;
        apb(0, 32'h500, 0); chk(rd, 1);
        @(negedge clk_i) chk(irq_o, 0);
        apb(1, 32'h504, 0);
        @(negedge clk_i) chk(irq_o, 1);
        apb(1, 32'h500, 1);
        @(negedge clk_i) chk(irq_o, 0);
    endtask : t_events
    task automatic t_frames;
        apb(1, 32'h4DC, 32'h0055);
        frame(3'd4, 6'h02, 2'b11, 0, 6'h02);
        for (int c = 0; c < 4; c++) begin
            apb(1, 32'h4DC, 32'h8000 | c * 32'h55);
            frame(3'd5, 6'h02, 2'b10, 0, {5'h01, c == 1 || c == 2});
            frame(3'd4, 6'h02, 2'b01, 0, {5'h01, c == 1 || c == 3});
            frame(3'd1, 6'h10, 2'b01, 0, {5'h08, c == 1 || c == 3});
            frame(3'd1, 6'h20, 2'b10, 0, {5'h10, c == 1 || c == 2});
        end
        for (int i = 0; i < 5; i++) begin
            apb(1, 32'h4DC, 32'h8001);
            frame(3'd4, 6'h02, 0, 5'h10 >> i, 6'h02);
            apb(1, 32'h4DC, 32'h8001 | 32'h4000 >> i);
            frame(3'd4, 6'h02, 0, 5'h10 >> i, 6'h03);
        end
        apb(1, 32'h4DC, 32'h8000);
        frame(3'd1, 6'h03, 0, 0, 6'h02);
        apb(1, 32'h4DC, 32'h8100);
        frame(3'd1, 6'h03, 0, 0, 6'h03);
        apb(1, 32'h4DC, 32'h8001);
        @(posedge clk_i) mon <= 3'd5;
        frame(3'd4, 6'h02, 0, 0, 6'h22);
    endtask : t_frames
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        t_regs;
        t_events;
        t_frames;
        end_of_test;
    end
    // Guard against a hang; the run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        end_of_test;
    end
endmodule : test_mirror_and_security_status_regs
